// File: design/qba_pkg.sv
package qba_pkg;

  // Register byte addresses on the plain register port.
  localparam logic [7:0] ADDR_DATA0 = 8'h00;
  localparam logic [7:0] ADDR_DATA1 = 8'h04;
  localparam logic [7:0] ADDR_DATA2 = 8'h08;
  localparam logic [7:0] ADDR_DATA3 = 8'h0c;
  localparam logic [7:0] ADDR_DATA_MASK = 8'hf3;
  localparam logic [7:0] ADDR_INDEX = 8'h10;
  localparam logic [7:0] ADDR_ARITHMETIC_STATUS_REGISTER = 8'h14;
  localparam logic [7:0] ADDR_INSN = 8'h18;
  localparam logic [7:0] ADDR_RESULT = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // Alignment index register fields.
  localparam int FIRST_IDX_LSB = 0;
  localparam int SECOND_IDX_LSB = 8;
  localparam logic [31:0] INDEX_MASK = 32'h0000_0303;

  // Arithmetic status register; the rounding select bit is kept but never used here.
  localparam int ARITHMETIC_STATUS_REGISTER_ROUND_BIT = 8;

  // Instruction word fields.
  localparam int INSN_KEY_LSB = 28;
  localparam logic [3:0] INSN_KEY = 4'hc;
  localparam int INSN_HALFWORD_BIT = 27;
  localparam int INSN_TRUNC_BIT = 26;
  localparam int INSN_HIGH_BIT = 25;
  localparam int INSN_REV_BIT = 24;
  localparam int INSN_SRC0_LSB = 20;
  localparam int INSN_SRC1_LSB = 16;
  localparam int INSN_DEST_LSB = 0;

  // Source pair codes.
  localparam logic [1:0] PAIR_LOW = 2'b00;
  localparam logic [1:0] PAIR_HIGH = 2'b01;

  // Status register fields.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_BAD_PAIR_BIT = 1;
  localparam int ST_BAD_KEY_BIT = 2;
  localparam int ST_DEST_LSB = 4;
  localparam int ST_COUNT_LSB = 8;

  // Reset values.
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [7:0] COUNT_RST = 8'h00;

  // Rounding biases added before the shift.
  localparam logic [9:0] ROUND_BIAS4 = 10'h002;
  localparam logic [8:0] ROUND_BIAS2 = 9'h001;

  typedef enum logic {QBA_IDLE, QBA_EXEC} qba_state_t;

  // Mean of two bytes, rounded up unless truncating.
  function automatic logic [7:0] qba_avg2(input logic [7:0] a, input logic [7:0] b,
                                          input logic trunc);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b} + (trunc ? 9'h000 : ROUND_BIAS2);
    return s[8:1];
  endfunction

  // Mean of four bytes, rounded to nearest with halves up, unless truncating.
  function automatic logic [7:0] qba_avg4(input logic [7:0] a, input logic [7:0] b,
                                          input logic [7:0] c, input logic [7:0] d,
                                          input logic trunc);
    logic [9:0] s;
    s = {2'b00, a} + {2'b00, b} + {2'b00, c} + {2'b00, d} + (trunc ? 10'h000 : ROUND_BIAS4);
    return s[9:2];
  endfunction

endpackage

// File: design/qba_align.sv
`timescale 1ns/1ps
`default_nettype none
module qba_align (
  input wire logic [31:0] lo_word, // Low register of the pair.
  input wire logic [31:0] hi_word, // High register of the pair.
  input wire logic reverse, // Swap the two registers.
  input wire logic [1:0] sel, // Byte offset of the window.
  output logic [31:0] window // Selected four bytes.
);
  logic [63:0] pair;

  // Build the eight-byte pair and slide a four-byte window over it.
  always_comb begin
    pair = reverse ? {lo_word, hi_word} : {hi_word, lo_word};
    window = pair[{sel, 3'b000} +: 32];
  end
endmodule // qba_align
`default_nettype wire

// File: design/qba_average.sv
`timescale 1ns/1ps
`default_nettype none
module qba_average (
  input wire logic [31:0] y, // First aligned operand.
  input wire logic [31:0] z, // Second aligned operand.
  input wire logic halfword, // Four-byte mean into half-words.
  input wire logic trunc, // Truncate instead of rounding.
  input wire logic high, // Place into upper byte of half-words.
  output logic [31:0] avg // Packed result.
);
  logic [7:0] upper;
  logic [7:0] lower;

  // Half-word means pair bytes 3,2 and 1,0 of both operands.
  always_comb begin
    upper = qba_pkg::qba_avg4(y[31:24], y[23:16], z[31:24], z[23:16], trunc);
    lower = qba_pkg::qba_avg4(y[15:8], y[7:0], z[15:8], z[7:0], trunc);
    if (halfword) begin
      if (high) begin
        avg = {upper, 8'h00, lower, 8'h00};
      end else begin
        avg = {8'h00, upper, 8'h00, lower};
      end
    end else begin
      avg = {qba_pkg::qba_avg2(y[31:24], z[31:24], trunc),
             qba_pkg::qba_avg2(y[23:16], z[23:16], trunc),
             qba_pkg::qba_avg2(y[15:8], z[15:8], trunc),
             qba_pkg::qba_avg2(y[7:0], z[7:0], trunc)};
    end
  end
endmodule // qba_average
`default_nettype wire

// File: design/qba_unit.sv
`timescale 1ns/1ps
`default_nettype none
module qba_unit (
  input wire logic mclk, // Core clock, 200 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [7:0] reg_addr, // Register byte address.
  input wire logic [31:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [31:0] reg_rdata, // Read data, cycle after the strobe.
  output logic [31:0] result_data, // Last result.
  output logic result_valid, // One-cycle pulse with a new result.
  output logic [2:0] result_dest // Destination register index of the result.
);
  logic [31:0] data_q [4];
  logic [31:0] index_q;
  logic [31:0] arithmetic_status_register_q;
  logic [31:0] insn_q;
  logic [31:0] rdata_q;
  logic [7:0] count_q;
  logic bad_pair_q;
  logic bad_key_q;
  qba_pkg::qba_state_t st_q;
  qba_pkg::qba_state_t st_d;
  logic wr_data;
  logic wr_insn;
  logic key_ok;
  logic is_halfword;
  logic is_trunc;
  logic is_high;
  logic is_rev;
  logic [1:0] code_a;
  logic [1:0] code_b;
  logic pair_ok;
  logic [31:0] lo_a;
  logic [31:0] hi_a;
  logic [31:0] lo_b;
  logic [31:0] hi_b;
  logic [1:0] sel_a;
  logic [1:0] sel_b;
  logic [31:0] win_a;
  logic [31:0] win_b;
  logic [31:0] avg;
  logic launch;

  // Write decode for the register port.
  assign wr_data = reg_wr && ((reg_addr & qba_pkg::ADDR_DATA_MASK) == qba_pkg::ADDR_DATA0);
  assign wr_insn = reg_wr && (reg_addr == qba_pkg::ADDR_INSN);
  assign key_ok = reg_wdata[qba_pkg::INSN_KEY_LSB +: 4] == qba_pkg::INSN_KEY;

  // Options are independent bits of the word, so their written order cannot matter.
  assign is_halfword = insn_q[qba_pkg::INSN_HALFWORD_BIT];
  assign is_trunc = insn_q[qba_pkg::INSN_TRUNC_BIT];
  assign is_high = insn_q[qba_pkg::INSN_HIGH_BIT];
  assign is_rev = insn_q[qba_pkg::INSN_REV_BIT];
  assign code_a = insn_q[qba_pkg::INSN_SRC0_LSB +: 2];
  assign code_b = insn_q[qba_pkg::INSN_SRC1_LSB +: 2];
  assign launch = st_q == qba_pkg::QBA_EXEC;

  // Source pair select; any code other than the two pairs is refused.
  always_comb begin
    pair_ok = (code_a == qba_pkg::PAIR_LOW || code_a == qba_pkg::PAIR_HIGH) &&
              (code_b == qba_pkg::PAIR_LOW || code_b == qba_pkg::PAIR_HIGH);
    lo_a = (code_a == qba_pkg::PAIR_LOW) ? data_q[0] : data_q[2];
    hi_a = (code_a == qba_pkg::PAIR_LOW) ? data_q[1] : data_q[3];
    lo_b = (code_b == qba_pkg::PAIR_LOW) ? data_q[0] : data_q[2];
    hi_b = (code_b == qba_pkg::PAIR_LOW) ? data_q[1] : data_q[3];
  end

  // Alignment: half-word form shares the first index, pair form uses both.
  always_comb begin
    sel_a = index_q[qba_pkg::FIRST_IDX_LSB +: 2];
    sel_b = is_halfword ? sel_a : index_q[qba_pkg::SECOND_IDX_LSB +: 2];
  end

  // Windows come from registers, so any index value is legal and never traps.
  qba_align u_align_a (
    .lo_word(lo_a),
    .hi_word(hi_a),
    .reverse(is_rev),
    .sel(sel_a),
    .window(win_a)
  );

  qba_align u_align_b (
    .lo_word(lo_b),
    .hi_word(hi_b),
    .reverse(is_rev),
    .sel(sel_b),
    .window(win_b)
  );

  // Datapath sees only the instruction's own truncate bit.
  qba_average u_average (
    .y(win_a),
    .z(win_b),
    .halfword(is_halfword),
    .trunc(is_trunc),
    .high(is_high),
    .avg(avg)
  );

  // Issue sequence: an accepted word runs in the following cycle.
  always_comb begin
    st_d = qba_pkg::QBA_IDLE;
    case (st_q)
      qba_pkg::QBA_IDLE: begin
        st_d = (wr_insn && key_ok) ? qba_pkg::QBA_EXEC : qba_pkg::QBA_IDLE;
      end
      qba_pkg::QBA_EXEC: begin
        st_d = (wr_insn && key_ok) ? qba_pkg::QBA_EXEC : qba_pkg::QBA_IDLE;
      end
      default: begin
        st_d = qba_pkg::QBA_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= qba_pkg::QBA_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Software-visible storage: data, indices, status and the instruction word.
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        data_q[i] <= qba_pkg::WORD_RST;
      end
      index_q <= qba_pkg::WORD_RST;
      arithmetic_status_register_q <= qba_pkg::WORD_RST;
      insn_q <= qba_pkg::WORD_RST;
    end else if (reg_wr) begin
      if (wr_data) begin
        data_q[reg_addr[3:2]] <= reg_wdata;
      end
      if (reg_addr == qba_pkg::ADDR_INDEX) begin
        index_q <= reg_wdata & qba_pkg::INDEX_MASK;
      end
      if (reg_addr == qba_pkg::ADDR_ARITHMETIC_STATUS_REGISTER) begin
        arithmetic_status_register_q <= reg_wdata;
      end
      if (wr_insn && key_ok) begin
        insn_q <= reg_wdata;
      end
    end
  end

  // Result capture; a refused pair leaves the result as it was.
  always_ff @(posedge mclk) begin
    if (rst) begin
      result_data <= qba_pkg::WORD_RST;
      result_valid <= 1'b0;
      result_dest <= 3'h0;
      count_q <= qba_pkg::COUNT_RST;
      bad_pair_q <= 1'b0;
    end else begin
      result_valid <= launch && pair_ok;
      if (launch) begin
        bad_pair_q <= !pair_ok;
        if (pair_ok) begin
          result_data <= avg;
          result_dest <= insn_q[qba_pkg::INSN_DEST_LSB +: 3];
          count_q <= count_q + 8'h01;
        end
      end
    end
  end

  // Malformed instruction words are flagged and otherwise ignored.
  always_ff @(posedge mclk) begin
    if (rst) begin
      bad_key_q <= 1'b0;
    end else if (wr_insn) begin
      bad_key_q <= !key_ok;
    end
  end

  // Read port answers in the next cycle only; unmapped addresses read zero.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= qba_pkg::WORD_RST;
    end else if (reg_rd) begin
      if ((reg_addr & qba_pkg::ADDR_DATA_MASK) == qba_pkg::ADDR_DATA0) begin
        rdata_q <= data_q[reg_addr[3:2]];
      end else begin
        case (reg_addr)
          qba_pkg::ADDR_INDEX: rdata_q <= index_q;
          qba_pkg::ADDR_ARITHMETIC_STATUS_REGISTER: rdata_q <= arithmetic_status_register_q;
          qba_pkg::ADDR_INSN: rdata_q <= insn_q;
          qba_pkg::ADDR_RESULT: rdata_q <= result_data;
          qba_pkg::ADDR_STATUS: begin
            rdata_q <= {16'h0000, count_q, 1'b0, result_dest, 1'b0, bad_key_q, bad_pair_q,
                        launch};
          end
          default: rdata_q <= qba_pkg::WORD_RST;
        endcase
      end
    end else begin
      rdata_q <= qba_pkg::WORD_RST;
    end
  end

  assign reg_rdata = rdata_q;

  // Sums of the aligned bytes, kept for the checks below.
  logic [9:0] chk_sum_lo;
  logic [8:0] chk_sum0;
  assign chk_sum_lo = {2'b00, win_a[15:8]} + {2'b00, win_a[7:0]} +
                      {2'b00, win_b[15:8]} + {2'b00, win_b[7:0]};
  assign chk_sum0 = {1'b0, win_a[7:0]} + {1'b0, win_b[7:0]};

  property p_low_zero;
    @(posedge mclk) disable iff (rst)
    launch && pair_ok && is_halfword && !is_high |=>
      result_data[31:24] == 8'h00 && result_data[15:8] == 8'h00;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low lane unused bytes not zero");

  property p_high_zero;
    @(posedge mclk) disable iff (rst)
    launch && pair_ok && is_halfword && is_high |=>
      result_data[23:16] == 8'h00 && result_data[7:0] == 8'h00 &&
      ({3'b000, result_data[15:8]} << 2) <= {1'b0, $past(chk_sum_lo)} + 11'd2;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("high lane unused bytes not zero");

  property p_trunc_range;
    @(posedge mclk) disable iff (rst)
    launch && pair_ok && is_halfword && !is_high && is_trunc |=>
      ({3'b000, result_data[7:0]} << 2) <= {1'b0, $past(chk_sum_lo)} &&
      {1'b0, $past(chk_sum_lo)} < ({3'b000, result_data[7:0]} << 2) + 11'd4;
  endproperty
  a_trunc_range: assert property (p_trunc_range) else $error("truncated mean wrong");

  property p_round_range;
    @(posedge mclk) disable iff (rst)
    launch && pair_ok && is_halfword && !is_high && !is_trunc |=>
      ({3'b000, result_data[7:0]} << 2) <= {1'b0, $past(chk_sum_lo)} + 11'd2 &&
      {1'b0, $past(chk_sum_lo)} + 11'd2 < ({3'b000, result_data[7:0]} << 2) + 11'd4;
  endproperty
  a_round_range: assert property (p_round_range) else $error("rounded mean wrong");

  property p_pair_round;
    @(posedge mclk) disable iff (rst)
    launch && pair_ok && !is_halfword && !is_trunc |=>
      {result_data[7:0], 1'b0} >= $past(chk_sum0) &&
      {result_data[7:0], 1'b0} <= $past(chk_sum0) + 9'd1;
  endproperty
  a_pair_round: assert property (p_pair_round) else $error("pair mean not rounded up");

  property p_bad_pair;
    @(posedge mclk) disable iff (rst)
    launch && !pair_ok |=> $stable(result_data) && bad_pair_q && !result_valid;
  endproperty
  a_bad_pair: assert property (p_bad_pair) else $error("invalid pair not refused");

  property p_flags_kept;
    @(posedge mclk) disable iff (rst)
    launch && !(reg_wr && reg_addr == qba_pkg::ADDR_ARITHMETIC_STATUS_REGISTER) |=> $stable(arithmetic_status_register_q);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("status flags changed");

  property p_reverse;
    @(posedge mclk) disable iff (rst)
    launch && is_rev && sel_a == 2'b00 |-> win_a == hi_a;
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse did not swap pair");

  property p_window3;
    @(posedge mclk) disable iff (rst)
    launch && !is_rev && sel_a == 2'b11 |-> win_a == {hi_a[23:0], lo_a[31:24]};
  endproperty
  a_window3: assert property (p_window3) else $error("window bytes 6..3 wrong");

  property p_shared_index;
    @(posedge mclk) disable iff (rst)
    launch && is_halfword |-> sel_b == index_q[1:0];
  endproperty
  a_shared_index: assert property (p_shared_index) else $error("half-word index not shared");

  property p_issue;
    @(posedge mclk) disable iff (rst)
    wr_insn && key_ok ##1 pair_ok |-> ##1 result_valid;
  endproperty
  a_issue: assert property (p_issue) else $error("issued word gave no result");

  c_halfword_high: cover property (@(posedge mclk) launch && pair_ok && is_halfword && is_high);
  c_pair_rev: cover property (@(posedge mclk) launch && pair_ok && !is_halfword && is_rev);
  c_bad_pair: cover property (@(posedge mclk) launch && !pair_ok);
  c_back_to_back: cover property (@(posedge mclk) result_valid ##1 result_valid);
endmodule // qba_unit
`default_nettype wire

// File: test/qba_host.sv
`timescale 1ns/1ps
`default_nettype none
module qba_host (
  input wire logic mclk, // Core clock.
  input wire logic [31:0] reg_rdata, // Read data from the unit.
  output logic [7:0] reg_addr, // Register byte address.
  output logic [31:0] reg_wdata, // Write data.
  output logic reg_wr, // Write strobe.
  output logic reg_rd // Read strobe.
);
  // The bus is idle at time zero.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write of a whole 32-bit word; keep leaves the strobe up for a back-to-back write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic keep);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    if (!keep) begin
      reg_wr <= 1'b0;
      reg_addr <= ~a; // A released bus shows no stale value.
      reg_wdata <= ~d;
      @(posedge mclk);
    end
  endtask

  // One-cycle read; the data stand only in the cycle after the strobe and are taken at its end.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge mclk);
    d = reg_rdata;
  endtask
endmodule // qba_host
`default_nettype wire

// File: test/qba_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module qba_unit_test;
  typedef struct {logic [31:0] d; logic [2:0] t; int due;} qba_exp_t;
  logic mclk, rst, reg_wr, reg_rd, result_valid, bp, bk;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, result_data, seed, last_res, got;
  logic [2:0] result_dest;
  int bad_count, compares, ncyc, tcyc, cnt;
  qba_exp_t q[$];

  qba_unit qba_unit_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .result_data(result_data),
    .result_valid(result_valid), .result_dest(result_dest));
  qba_host qba_host_inst (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // Clock of 5 ns period.
  always #2.5 mclk = ~mclk;

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  // Pseudo-random source.
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Four-byte window of a register pair, optionally reversed.
  function automatic logic [31:0] win(input logic [31:0] lo, input logic [31:0] hi,
                                      input logic rev, input logic [1:0] s);
    logic [63:0] p;
    p = rev ? {lo, hi} : {hi, lo};
    p = p >> (8 * s);
    return p[31:0];
  endfunction

  // Reference result of one accepted instruction word.
  function automatic logic [31:0] model(input logic [31:0] ins, input logic [31:0] r[4],
                                        input logic [31:0] idx);
    logic [31:0] y, z, res;
    int a, b;
    y = win(r[2 * ins[20]], r[2 * ins[20] + 1], ins[24], idx[1:0]);
    z = win(r[2 * ins[16]], r[2 * ins[16] + 1], ins[24], ins[27] ? idx[1:0] : idx[9:8]);
    res = 32'h0000_0000;
    if (ins[27]) begin
      a = (y[31:24] + y[23:16] + z[31:24] + z[23:16] + (ins[26] ? 0 : 2)) >> 2;
      b = (y[15:8] + y[7:0] + z[15:8] + z[7:0] + (ins[26] ? 0 : 2)) >> 2;
      res = ins[25] ? {a[7:0], 8'h00, b[7:0], 8'h00} : {8'h00, a[7:0], 8'h00, b[7:0]};
    end else begin
      for (int k = 0; k < 4; k++) begin
        a = (y[8 * k +: 8] + z[8 * k +: 8] + (ins[26] ? 0 : 1)) >> 1;
        res[8 * k +: 8] = a[7:0];
      end
    end
    return res;
  endfunction

  // Writes one instruction word and queues what it must produce.
  task automatic issue(input logic [31:0] ins, input logic [31:0] r[4], input logic [31:0] idx,
                       input logic keep);
    qba_exp_t e;
    e.due = ncyc + 3;
    qba_host_inst.wr(qba_pkg::ADDR_INSN, ins, keep);
    if (ins[31:28] !== qba_pkg::INSN_KEY) begin
      bk = 1'b1;
    end else begin
      bk = 1'b0;
      bp = ins[21] | ins[17];
      if (!bp) begin
        e.d = model(ins, r, idx);
        e.t = ins[2:0];
        last_res = e.d;
        cnt++;
        q.push_back(e);
      end
    end
  endtask

  // Loads random operands and runs two instructions, then reads the side registers.
  task automatic run_op();
    logic [31:0] r[4];
    logic [31:0] idx, ast, ins;
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      r[k] = seed;
      qba_host_inst.wr(qba_pkg::ADDR_DATA0 + 8'(4 * k), seed, 1'b1);
    end
    seed = lfsr(seed);
    idx = seed;
    qba_host_inst.wr(qba_pkg::ADDR_INDEX, idx, 1'b1);
    seed = lfsr(seed);
    ast = seed;
    qba_host_inst.wr(qba_pkg::ADDR_ARITHMETIC_STATUS_REGISTER, ast, 1'b1);
    seed = lfsr(seed);
    ins = {(seed[31:29] == 3'b000) ? 4'h3 : qba_pkg::INSN_KEY, seed[27:24], 2'b00,
           seed[21] & seed[9] & seed[10], seed[20], 2'b00, seed[17] & seed[11] & seed[12],
           seed[16], 13'h0000, seed[2:0]};
    issue(ins, r, idx, seed[5]);
    issue(ins ^ 32'h0600_0000, r, idx, 1'b0);
    qba_host_inst.rd(qba_pkg::ADDR_ARITHMETIC_STATUS_REGISTER, got);
    chk(got, ast, "arithmetic_status_register");
    qba_host_inst.rd(qba_pkg::ADDR_RESULT, got);
    chk(got, last_res, "result reg");
    qba_host_inst.rd(qba_pkg::ADDR_STATUS, got);
    chk(got & 32'h0000_ff06, {16'h0000, 8'(cnt), 5'h00, bk, bp, 1'b0}, "status");
    qba_host_inst.rd(qba_pkg::ADDR_INDEX, got);
    chk(got, idx & qba_pkg::INDEX_MASK, "index");
  endtask

  // Compares each result pulse with the queued reference, including its cycle.
  always @(negedge mclk) begin
    ncyc++;
    if (q.size() > 0 && q[0].due < ncyc) begin
      chk(32'h0, 32'h1, "missing result");
      void'(q.pop_front());
    end
    if (rst === 1'b0 && result_valid !== 1'b0) begin
      if (q.size() == 0) begin
        chk(32'h1, 32'h0, "unexpected result");
      end else begin
        chk(result_data, q[0].d, "data");
        chk({29'h0, result_dest}, {29'h0, q[0].t}, "dest");
        chk(32'(ncyc), 32'(q[0].due), "timing");
        void'(q.pop_front());
      end
    end
  end

  // Cuts a hung run short.
  always @(posedge mclk) begin
    tcyc++;
    if (tcyc == 12000) begin
      bad_count++;
      $display("MISMATCH at %0t: run timed out", $time);
      end_sim();
    end
  end

  // Main sequence.
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    seed = 32'h999fe124;
    bad_count = 0;
    compares = 0;
    ncyc = 0;
    tcyc = 0;
    cnt = 0;
    bp = 1'b0;
    bk = 1'b0;
    last_res = 32'h0000_0000;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    qba_host_inst.rd(qba_pkg::ADDR_RESULT, got);
    chk(got, 32'h0000_0000, "result after reset");
    qba_host_inst.rd(qba_pkg::ADDR_STATUS, got);
    chk(got, 32'h0000_0000, "status after reset");
    qba_host_inst.wr(8'h24, 32'hffff_ffff, 1'b0);
    qba_host_inst.rd(8'h24, got);
    chk(got, 32'h0000_0000, "unmapped read");
    $display("Test reset and map done");
    for (int i = 0; i < 150; i++) begin
      run_op();
    end
    repeat (4) @(posedge mclk);
    chk(32'(q.size()), 32'h0, "results left over");
    $display("Test random operations done");
    end_sim();
  end
endmodule // qba_unit_test
`default_nettype wire
